// ### otpp_map.svh
// timing counts and address constants for the otp byte programmer
`ifndef OTPP_MAP_SVH
`define OTPP_MAP_SVH
// ----------------------------------------
// clock and timing
// ----------------------------------------
`define OTPP_CLK_HZ 25000000
`define OTPP_PW_NOM_NS 200000
`define OTPP_PW_NOM_CYC ((`OTPP_PW_NOM_NS * (`OTPP_CLK_HZ / 1000000) + 999) / 1000)
`define OTPP_PW_MIN_NS 190000
`define OTPP_PW_MAX_NS 210000
`define OTPP_PW_MIN_CYC ((`OTPP_PW_MIN_NS * (`OTPP_CLK_HZ / 1000000) + 999) / 1000)
`define OTPP_PW_MAX_CYC ((`OTPP_PW_MAX_NS * (`OTPP_CLK_HZ / 1000000)) / 1000)
`define OTPP_OPW_MIN_NS 190000
`define OTPP_OPW_MAX_NS 5250000
`define OTPP_OPW_MIN_CYC ((`OTPP_OPW_MIN_NS * (`OTPP_CLK_HZ / 1000000) + 999) / 1000)
`define OTPP_OPW_MAX_CYC ((`OTPP_OPW_MAX_NS * (`OTPP_CLK_HZ / 1000000)) / 1000)
`define OTPP_SETUP_NS 2000
`define OTPP_SETUP_CYC ((`OTPP_SETUP_NS * (`OTPP_CLK_HZ / 1000000) + 999) / 1000)
`define OTPP_OE_DLY_NS 150
`define OTPP_OE_DLY_CYC ((`OTPP_OE_DLY_NS * (`OTPP_CLK_HZ / 1000000) + 999) / 1000)
// ----------------------------------------
// address space
// ----------------------------------------
`define OTPP_ADDR_LAST 17'h07FFF
`define OTPP_BLANK 8'hFF
`define OTPP_RETRY_MAX 25
`endif

// ### otpp_pkg.sv
// types for the otp byte programmer
package otpp_pkg;
  typedef struct packed {
    logic chip_sel_low;
    logic out_gate_low;
    logic program_strobe_low;
  } otpp_ctl_t;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_SETUP = 4'h1,
    ST_PULSE = 4'h2,
    ST_HOLD = 4'h3,
    ST_VSET = 4'h4,
    ST_VREAD = 4'h5,
    ST_OVER = 4'h6,
    ST_OHOLD = 4'h7,
    ST_DONE = 4'h8
  } otpp_state_t;
endpackage

// ### otpp_programmer.sv
// host-side byte programmer driving an otp rom in its eprom-style mode
`timescale 1ns/1ps
`include "otpp_map.svh"
module otpp_programmer
  import otpp_pkg::*;
#(
  parameter int OPW_CYC = `OTPP_OPW_MIN_CYC * 3,
  parameter int RETRY_MAX = `OTPP_RETRY_MAX
) (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_sys_rst,
  // user request
  input wire logic i_start,
  input wire logic [16:0] i_addr,
  input wire logic [7:0] i_data,
  output logic o_ready,
  output logic o_done,
  output logic o_fail,
  output logic o_halted,
  input wire logic i_clear_halt,
  // device pins
  output otpp_ctl_t o_ctl,
  output logic [16:0] o_byte_address_lines,
  output logic [7:0] o_byte_data_lines,
  output logic o_byte_data_oe_n,
  input wire logic [7:0] i_byte_data_lines
);
  // ----------------------------------------
  // timing constants
  // ----------------------------------------
  localparam int PW_CYC = `OTPP_PW_NOM_CYC;
  localparam int PW_MIN = `OTPP_PW_MIN_CYC;
  localparam int PW_MAX = `OTPP_PW_MAX_CYC;
  localparam int SU_CYC = `OTPP_SETUP_CYC;
  localparam int RD_CYC = `OTPP_OE_DLY_CYC + 1;
  localparam int OPW_USE = (OPW_CYC < `OTPP_OPW_MIN_CYC) ? `OTPP_OPW_MIN_CYC :
                           (OPW_CYC > `OTPP_OPW_MAX_CYC) ? `OTPP_OPW_MAX_CYC : OPW_CYC;

  otpp_state_t state, next_state;
  logic [17:0] count;
  logic [7:0] tries;
  logic [16:0] addr;
  logic [7:0] data;
  logic last_fail;

  // request decode; out-of-array or all-ones bytes need no pulses
  wire start_ok = i_start && state == ST_IDLE && !o_halted;
  wire in_array = i_addr <= `OTPP_ADDR_LAST;
  wire skip = !in_array || i_data == `OTPP_BLANK;
  wire cnt_end = count == 18'h00000;
  wire match = i_byte_data_lines == data;
  wire over_limit = tries >= 8'(RETRY_MAX);

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: if (start_ok && !skip) next_state = ST_SETUP;
      ST_SETUP: if (cnt_end) next_state = ST_PULSE;
      ST_PULSE: if (cnt_end) next_state = ST_HOLD;
      ST_HOLD: if (cnt_end) next_state = ST_VSET;
      ST_VSET: if (cnt_end) next_state = ST_VREAD;
      ST_VREAD: begin
        if (cnt_end) begin
          if (match) next_state = ST_OVER;
          else if (over_limit) next_state = ST_DONE;
          else next_state = ST_SETUP;
        end
      end
      ST_OVER: if (cnt_end) next_state = ST_OHOLD;
      ST_OHOLD: if (cnt_end) next_state = ST_DONE;
      ST_DONE: next_state = ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
  end

  // load the down-counter on each state entry
  function automatic logic [17:0] load_of(input otpp_state_t s);
    case (s)
      ST_SETUP, ST_HOLD, ST_VSET, ST_OHOLD: load_of = 18'(SU_CYC - 1);
      ST_PULSE: load_of = 18'(PW_CYC - 1);
      ST_VREAD: load_of = 18'(RD_CYC - 1);
      ST_OVER: load_of = 18'(OPW_USE - 1);
      default: load_of = 18'h00000;
    endcase
  endfunction

  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state <= ST_IDLE;
      count <= 18'h00000;
    end else begin
      state <= next_state;
      count <= (next_state != state) ? load_of(next_state) : count - 18'h00001;
    end
  end

  // captured request, one byte at a time
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      addr <= 17'h00000;
      data <= 8'h00;
    end else if (start_ok) begin
      addr <= i_addr;
      data <= i_data;
    end
  end

  // retry counter per byte
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) tries <= 8'h00;
    else if (start_ok) tries <= 8'h00;
    else if (state == ST_PULSE && next_state == ST_HOLD) tries <= tries + 8'h01;
  end

  // result flags; two failing bytes with no passing byte between halt the run
  wire byte_fail = state == ST_VREAD && cnt_end && !match && over_limit;
  wire byte_pass = state == ST_OHOLD && cnt_end;
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_done <= 1'b0;
      o_fail <= 1'b0;
      last_fail <= 1'b0;
      o_halted <= 1'b0;
    end else begin
      o_done <= byte_fail || byte_pass || (start_ok && skip);
      o_fail <= byte_fail;
      if (byte_fail) last_fail <= 1'b1;
      else if (byte_pass) last_fail <= 1'b0;
      if (byte_fail && last_fail) o_halted <= 1'b1;
      else if (i_clear_halt) o_halted <= 1'b0;
    end
  end

  assign o_ready = state == ST_IDLE && !o_halted;

  // ----------------------------------------
  // pin drive
  // ----------------------------------------
  // strobe low only in pulse states; gate low only for verify
  wire pulsing = state == ST_PULSE || state == ST_OVER;
  wire verifying = state == ST_VSET || state == ST_VREAD;
  wire active = state != ST_IDLE && state != ST_DONE;
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_ctl <= '{chip_sel_low: 1'b1, out_gate_low: 1'b1, program_strobe_low: 1'b1};
      o_byte_data_oe_n <= 1'b1;
      o_byte_address_lines <= 17'h00000;
      o_byte_data_lines <= 8'h00;
    end else begin
      o_ctl.chip_sel_low <= !(next_state != ST_IDLE && next_state != ST_DONE);
      o_ctl.out_gate_low <= !(next_state == ST_VSET || next_state == ST_VREAD);
      o_ctl.program_strobe_low <= !(next_state == ST_PULSE || next_state == ST_OVER);
      // release data in the same cycle that gates the device onto the lines
      o_byte_data_oe_n <= next_state == ST_VSET || next_state == ST_VREAD ||
                          next_state == ST_IDLE || next_state == ST_DONE;
      o_byte_address_lines <= start_ok ? i_addr : addr;
      o_byte_data_lines <= start_ok ? i_data : data;
    end
  end

  // ----------------------------------------
  // pulse width monitor
  // ----------------------------------------
  // counted on the pin itself, so a broken counter load cannot hide a bad width
  logic [17:0] low_len;
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) low_len <= 18'h00000;
    else if (!o_ctl.program_strobe_low) low_len <= low_len + 18'h00001;
    else low_len <= 18'h00000;
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence init_end_s;
    $rose(o_ctl.program_strobe_low) ##0 state == ST_HOLD;
  endsequence
  sequence over_end_s;
    $rose(o_ctl.program_strobe_low) ##0 state == ST_OHOLD;
  endsequence
  init_span_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    init_end_s |-> low_len >= 18'(PW_MIN) && low_len <= 18'(PW_MAX))
    else $error("initial pulse width out of window");
  over_span_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    over_end_s |-> low_len >= 18'(`OTPP_OPW_MIN_CYC) && low_len <= 18'(`OTPP_OPW_MAX_CYC))
    else $error("overprogram pulse width out of window");
  over_after_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    state == ST_VREAD && cnt_end && match |=> state == ST_OVER)
    else $error("overprogram pulse skipped");
  sequence pulse_rise_s;
    $rose(state == ST_PULSE);
  endsequence
  property pulse_len_p;
    @(posedge i_clock) disable iff (i_sys_rst)
      pulse_rise_s |-> (state == ST_PULSE) [*5] ##0 1'b1;
  endproperty
  pulse_width_a: assert property (pulse_len_p) else $error("short program pulse");
  over_min_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    $rose(state == ST_OVER) |-> (state == ST_OVER) [*8]) else $error("short overprogram pulse");
  no_contend_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    !o_ctl.out_gate_low |-> o_byte_data_oe_n) else $error("data contention");
  strobe_gate_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    !o_ctl.program_strobe_low |-> o_ctl.out_gate_low && !o_ctl.chip_sel_low)
    else $error("illegal pin combination");
  range_only_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    !o_ctl.program_strobe_low |-> o_byte_address_lines <= `OTPP_ADDR_LAST)
    else $error("program outside array");
  blank_skip_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    start_ok && skip |=> o_done && state == ST_IDLE) else $error("blank byte not skipped");
  halt_two_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    byte_fail && last_fail |=> o_halted) else $error("run not halted");
  one_byte_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    state != ST_IDLE |=> $stable(addr)) else $error("address moved mid byte");
  retry_cap_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    state == ST_VREAD && cnt_end && !match && !over_limit |=> state == ST_SETUP)
    else $error("retry not taken");
endmodule

// ### otpp_dev_model.sv
// behavioural otp rom seen through its programming pins
`timescale 1ns/1ps
module otpp_dev_model
  import otpp_pkg::*;
(
  // clock and fault control
  input wire logic i_clock,
  input wire logic i_break,
  // device pins
  input otpp_ctl_t i_ctl,
  input wire logic [16:0] i_addr,
  input wire logic [7:0] i_data,
  input wire logic i_oe_n,
  output logic [7:0] o_data,
  output logic o_err
);
  logic [7:0] mem [0:32767];
  logic [7:0] last = 8'hFF;
  int width = 0;
  logic err_flag = 1'b0;
  assign o_err = err_flag;
  // ----------------------------------------
  // mode decode
  // ----------------------------------------
  wire wr = !i_ctl.chip_sel_low && i_ctl.out_gate_low && !i_ctl.program_strobe_low;
  wire rd = !i_ctl.chip_sel_low && !i_ctl.out_gate_low && i_ctl.program_strobe_low;
  initial begin
    foreach (mem[i]) mem[i] = 8'hFF;
  end
  // program on strobe release; a cut-short pulse is flagged as an error
  always @(posedge i_clock) begin
    if (wr) begin
      width <= width + 1;
    end else if (width != 0) begin
      if (width < 4750 || width > 131250) err_flag <= 1'b1;
      if (!i_break && i_addr < 17'h08000) mem[i_addr[14:0]] <= mem[i_addr[14:0]] & i_data;
      width <= 0;
    end
    if (rd && !i_oe_n) err_flag <= 1'b1;
  end
  // floated lines show a toggling pattern so stale data never passes
  always @(posedge i_clock) last <= rd ? mem[i_addr[14:0]] : ~last;
  assign o_data = last;
endmodule

// ### otpp_programmer_tb_top.sv
// self-checking bench for the otp byte programmer
`timescale 1ns/1ps
module otpp_programmer_tb_top;
  logic i_clock = 1'b0;
  logic i_sys_rst = 1'b1;
  logic i_start = 1'b0;
  logic i_clear_halt = 1'b0;
  logic brk = 1'b0;
  logic [16:0] i_addr = 17'h00000;
  logic [7:0] i_data = 8'h00;
  logic o_ready, o_done, o_fail, o_halted, oe_n, err;
  logic [16:0] pa;
  logic [7:0] hd, dq, pd;
  otpp_pkg::otpp_ctl_t ctl;
  int error_cnt = 0;
  int cmp_count = 0;
  int seed = 46194;
  int cf = 0;
  logic [7:0] exp_mem [int];
  wire [7:0] dbus = oe_n ? dq : hd;
  always #20 i_clock = ~i_clock;
  otpp_programmer #(.OPW_CYC(4750), .RETRY_MAX(2)) dut_u (.i_clock(i_clock),
    .i_sys_rst(i_sys_rst), .i_start(i_start), .i_addr(i_addr), .i_data(i_data),
    .o_ready(o_ready), .o_done(o_done), .o_fail(o_fail), .o_halted(o_halted),
    .i_clear_halt(i_clear_halt), .o_ctl(ctl), .o_byte_address_lines(pa),
    .o_byte_data_lines(hd), .o_byte_data_oe_n(oe_n), .i_byte_data_lines(dbus));
  otpp_dev_model dev_u (.i_clock(i_clock), .i_break(brk), .i_ctl(ctl), .i_addr(pa),
    .i_data(dbus), .i_oe_n(oe_n), .o_data(dq), .o_err(err));
  // ----------------------------------------
  // compare and closing tasks
  // ----------------------------------------
  task automatic chk_bit(input string n, input logic e, input logic g);
    cmp_count++;
    if (g !== e) begin
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
      error_cnt++;
    end
  endtask
  task automatic chk_byte(input string n, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
      error_cnt++;
    end
  endtask
  task automatic conclude();
    if (error_cnt == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // one byte request; the expectation comes from the bench's own memory model
  task automatic prog(input logic [16:0] a, input logic [7:0] d);
    int n;
    logic skip;
    skip = (a > 17'h07FFF) || (d == 8'hFF);
    chk_bit("ready", 1'b1, o_ready);
    i_addr <= a;
    i_data <= d;
    i_start <= 1'b1;
    @(posedge i_clock);
    i_start <= 1'b0;
    n = 0;
    while (o_done !== 1'b1 && n < 30000) begin
      @(posedge i_clock);
      n++;
    end
    chk_bit("done", 1'b1, o_done);
    chk_bit("fail", brk && !skip, o_fail);
    if (!skip) begin
      cf = brk ? cf + 1 : 0;
      if (!brk) exp_mem[int'(a)] = d;
      if (exp_mem.exists(int'(a))) chk_byte("cell", exp_mem[int'(a)], dev_u.mem[a[14:0]]);
    end
    repeat (2) @(posedge i_clock);
    chk_bit("halted", cf >= 2, o_halted);
    chk_byte("ctl", 8'h07, {5'h00, ctl});
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (3) @(posedge i_clock);
    i_sys_rst <= 1'b0;
    @(posedge i_clock);
    pd = 8'($random(seed)) & 8'hFE;
    prog(17'h00000, pd);
    prog(17'h07FFF, ~pd & 8'h7F);
    prog(17'h08000, pd);
    prog(17'h1FFFF, 8'h00);
    prog(17'($random(seed)) & 17'h07FFF, 8'hFF);
    brk <= 1'b1;
    prog(17'h00100, pd);
    prog(17'h00101, pd);
    i_start <= 1'b1;
    repeat (5) @(posedge i_clock);
    chk_bit("refused", 1'b1, ctl.chip_sel_low);
    i_start <= 1'b0;
    i_clear_halt <= 1'b1;
    brk <= 1'b0;
    cf = 0;
    @(posedge i_clock);
    i_clear_halt <= 1'b0;
    repeat (2) @(posedge i_clock);
    // kept clear of the cells already written so a fresh byte is always blank
    prog((17'($random(seed)) & 17'h03FFE) | 17'h04000, pd ^ 8'h01);
    chk_bit("pin timing", 1'b0, err);
    conclude();
  end
  // hang guard, some 30000 cycles beyond the longest expected run
  initial begin
    repeat (80000) @(posedge i_clock);
    error_cnt++;
    conclude();
  end
endmodule
